/* File: verilog/hpc_regs.sv */
// hot plug controller working register set
`timescale 1ns/1ps
module hpc_regs #(
  parameter int ARB_TIMEOUT = 8388608
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              hotplugEnable,
  input  wire logic [5:0]        regAddr,
  input  wire logic              regWr,
  input  wire logic              regRd,
  input  wire logic [3:0]        regBe,
  input  wire logic [31:0]       regWdata,
  output logic [31:0]            regRdata,
  input  wire logic [2:0]        busMode,
  input  wire logic [3:0][1:0]   slotState,
  input  wire logic [3:0][2:0]   slotMaxMode,
  input  wire logic [3:0]        latchOpen,
  input  wire logic [3:0][4:0]   slotIrqStatus,
  input  wire logic [3:0][4:0]   slotIrqMask,
  input  wire logic [3:0][1:0]   slotSerrStatus,
  input  wire logic [3:0][1:0]   slotSerrMask,
  input  wire logic              hpBusReq,
  input  wire logic              busGrant,
  input  wire logic              pclkTick,
  input  wire logic              opDone,
  output hpc_pkg::hpc_op_t       op,
  output logic                   controllerBusy,
  output logic                   wakeTerm,
  output logic                   controllerIrq,
  output logic                   controllerSyserr
);
  if (ARB_TIMEOUT < 2 || ARB_TIMEOUT > 16777215) begin : g_bad_timeout
    $error("ARB_TIMEOUT out of range");
  end

  localparam logic [23:0] ATO_LAST = 24'(ARB_TIMEOUT - 1);
  localparam logic [23:0] ATO_FULL = 24'(ARB_TIMEOUT);
  localparam int          CC_BIT   = hpc_pkg::COMPLETION_STATUS_BIT;
  localparam int          ATO_BIT  = hpc_pkg::ATO_STS_BIT;

  hpc_pkg::hpc_state_t s, next_s;
  hpc_pkg::hpc_kind_t  chkKind;
  logic [2:0]          chkErr;
  logic [3:0]          irqPend, serrPend;
  logic [4:0]          irqLoc, serrLoc;
  logic                wr, rd, busyFall, wakeNow, serrNow;
  logic [31:0]         word, wd;
  logic [3:0]          be;
  logic [31:0]         bmask;

  hpc_cmd_check u_check (
    .code        (regWdata[7:0]),
    .target_slot         (regWdata[12:8]),
    .slots_implemented         (s.slotCfg[4:0]),
    .curMode     (busMode),
    .avail1      (s.avail1),
    .avail2      (s.avail2),
    .slotState   (slotState),
    .slotMaxMode (slotMaxMode),
    .latchOpen   (latchOpen),
    .kind        (chkKind),
    .err         (chkErr)
  );

  always_comb begin
    wr = regWr && hotplugEnable; // [R1]
    rd = regRd && hotplugEnable;
    for (int i = 0; i < 4; i++) begin
      irqPend[i]  = |(slotIrqStatus[i] & ~slotIrqMask[i]); // [R16]
      serrPend[i] = |(slotSerrStatus[i] & ~slotSerrMask[i]); // [R18]
    end
    irqLoc  = {irqPend, s.ccSts & ~s.mask[2]}; // [R17]
    serrLoc = {serrPend, s.atoSts & ~s.mask[3]}; // [R19]
    wakeNow = irqLoc != 5'h00; // [R20]
    serrNow = !s.mask[1] && serrLoc != 5'h00; // [R22]
    // a 16-bit write at the upper half moves its low lanes up to the upper half
    if (regAddr[1]) begin
      wd = {regWdata[15:0], regWdata[15:0]};
      be = {regBe[1:0], 2'h0};
    end else begin
      wd = regWdata;
      be = regBe;
    end
    for (int b = 0; b < 4; b++) bmask[b*8 +: 8] = {8{be[b]}};
    word = 32'h0;
    if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_BASE) word = 32'h0; // [R2]
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_AVAIL1) word = s.avail1;
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_AVAIL2) word = s.avail2;
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_SLOTCFG) word = s.slotCfg;
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_BUSCFG)
      word = {hpc_pkg::PROG_IF_DEFAULT, 21'h0, busMode}; // [R5]
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_CMD)
      word = {12'h0, s.err, s.busy, s.cmd}; // [R15]
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_IRQLOC) word = {27'h0, irqLoc};
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_SERRLOC) word = {27'h0, serrLoc};
    else if ({regAddr[5:2], 2'h0} == hpc_pkg::OFF_SERRINT)
      word = {14'h0, s.atoSts, s.ccSts, 12'h0, s.mask};
    if (regAddr[1]) word = {16'h0, word[31:16]};

    next_s = s;
    next_s.op.start = 1'b0;
    if (rd) next_s.rdata = word;
    else if (regRd) next_s.rdata = 32'h0; // [R1]

    if (wr && {regAddr[5:2], 2'h0} == hpc_pkg::OFF_AVAIL1 && !s.locked[0]) begin
      next_s.avail1 = (s.avail1 & ~bmask) | (wd & bmask & hpc_pkg::AVAIL1_MASK); // [R3]
      next_s.locked[0] = 1'b1;
    end
    if (wr && {regAddr[5:2], 2'h0} == hpc_pkg::OFF_AVAIL2 && !s.locked[1]) begin
      next_s.avail2 = (s.avail2 & ~bmask) | (wd & bmask & hpc_pkg::AVAIL2_MASK); // [R3]
      next_s.locked[1] = 1'b1;
    end
    if (wr && {regAddr[5:2], 2'h0} == hpc_pkg::OFF_SLOTCFG && !s.locked[2]) begin
      next_s.slotCfg = (s.slotCfg & ~bmask) | (wd & bmask & hpc_pkg::SLOTCFG_MASK); // [R4]
      next_s.locked[2] = 1'b1;
    end

    // completion: a failed command drops busy one cycle after acceptance
    busyFall = s.busy && (s.failing || opDone);
    if (busyFall) begin
      next_s.busy = 1'b0; // [R15]
      next_s.failing = 1'b0;
      next_s.err = s.errPend; // [R10] [R11]
      next_s.ccSts = 1'b1; // [R24]
    end
    // the command word is checked only when whole, so both low lanes are needed
    if (wr && regAddr == hpc_pkg::OFF_CMD && be[1:0] == 2'h3 && !s.busy) begin // [R6]
      next_s.cmd = wd[15:0] & hpc_pkg::CMD_MASK;
      next_s.busy = 1'b1;
      next_s.failing = chkErr != 3'h0;
      next_s.errPend = chkErr; // shown only when busy falls, old bits stay until then
      next_s.op.start = chkErr == 3'h0;
      next_s.op.kind = chkKind;
      next_s.op.target = chkKind == hpc_pkg::OP_SLOT ? wd[12:8] : 5'h00; // [R7]
      next_s.op.attn = hpc_pkg::hpc_ind_t'(wd[5:4]); // [R8]
      next_s.op.power = hpc_pkg::hpc_ind_t'(wd[3:2]); // [R8]
      next_s.op.slot = hpc_pkg::hpc_ss_t'(wd[1:0]); // [R9]
      next_s.op.mode = wd[2:0];
    end

    if (hpBusReq && !busGrant) begin
      if (pclkTick && s.arbCnt != ATO_FULL) next_s.arbCnt = s.arbCnt + 24'h1;
    end else begin
      next_s.arbCnt = 24'h0;
    end
    if (wr && {regAddr[5:2], 2'h0} == hpc_pkg::OFF_SERRINT) begin
      if (be[0]) next_s.mask = wd[3:0];
      if (be[2] && wd[CC_BIT]) next_s.ccSts = 1'b0;
      if (be[2] && wd[ATO_BIT]) next_s.atoSts = 1'b0;
    end
    // hardware set wins over a same-cycle clear
    if (busyFall) next_s.ccSts = 1'b1; // [R24]
    if (hpBusReq && !busGrant && pclkTick && s.arbCnt == ATO_LAST)
      next_s.atoSts = 1'b1; // [R23]

    next_s.wake = wakeNow;
    next_s.irq = wakeNow && !s.mask[0]; // [R21]
    next_s.serr = serrNow;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s <= '0;
      s.mask <= hpc_pkg::MASK_RESET; // [R24]
    end else begin
      s <= next_s;
    end
  end

  assign regRdata = s.rdata;
  assign op = s.op;
  assign controllerBusy = s.busy;
  assign wakeTerm = s.wake;
  assign controllerIrq = s.irq;
  assign controllerSyserr = s.serr;

  sequence cmdWrite;
    wr && regAddr == hpc_pkg::OFF_CMD && regBe[1:0] == 2'h3;
  endsequence
  sequence busyDrop;
    s.busy ##1 !s.busy;
  endsequence

  a_busy_blocks_cmd: assert property (@(posedge clk_sys) disable iff (srst) // [R6]
    s.busy ##0 cmdWrite |=> $stable(s.cmd))
    else $error("command changed while busy");
  a_cmd_sets_busy: assert property (@(posedge clk_sys) disable iff (srst) // [R15]
    !s.busy ##0 cmdWrite |=> s.busy)
    else $error("accepted command did not set busy");
  a_fall_sets_cc: assert property (@(posedge clk_sys) disable iff (srst) // [R24]
    busyDrop |-> s.ccSts)
    else $error("busy fall without completion status");
  a_err_onehot: assert property (@(posedge clk_sys) disable iff (srst) // [R10]
    $onehot0(s.err))
    else $error("more than one error bit");
  a_err_held: assert property (@(posedge clk_sys) disable iff (srst) // [R11]
    !$fell(s.busy) |-> $stable(s.err))
    else $error("error bit changed before busy fall");
  a_fail_quick: assert property (@(posedge clk_sys) disable iff (srst) // [R13]
    !s.busy ##0 cmdWrite ##0 (chkErr != 3'h0) |=> s.busy ##1 !s.busy && s.ccSts)
    else $error("failed command did not complete at once");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (srst) // [R21]
    controllerIrq |-> $past(wakeNow) && !$past(s.mask[0]))
    else $error("interrupt without unmasked wake");
  a_serr_gate: assert property (@(posedge clk_sys) disable iff (srst) // [R22]
    $past(serrLoc[0]) && !$past(s.mask[1]) |-> controllerSyserr)
    else $error("arbiter timeout did not raise system error");
  a_cc_locator: assert property (@(posedge clk_sys) disable iff (srst) // [R17]
    s.ccSts && !s.mask[2] |=> wakeTerm)
    else $error("completion locator missing");
  a_mask_reset: assert property (@(posedge clk_sys) // [R24]
    srst |=> s.mask == hpc_pkg::MASK_RESET && !s.busy)
    else $error("masks not set by reset");
  a_disabled_read: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
    regRd && !hotplugEnable |=> regRdata == 32'h0)
    else $error("read while disabled not zero");
  a_ato_count: assert property (@(posedge clk_sys) disable iff (srst) // [R23]
    !(hpBusReq && !busGrant) |=> s.arbCnt == 24'h0)
    else $error("arbiter counter not cleared");
endmodule : hpc_regs

/* File: verilog/hpc_pkg.sv */
// hot plug controller register set: shared constants and types
// Function
// R1 - hot plug disabled makes whole set reserved
// R2 - base offset word always reads zero
// R3 - write-once slot counts per bus mode
// R4 - slot configuration word fields held
// R5 - current bus mode read-only code
// R6 - command writes dropped while busy
// R7 - target applies only to slot operations
// R8 - indicator field decode keep/on/blink/off
// R9 - slot state field decode
// R10 - busy fall updates at most one error
// R11 - error bits held until next busy fall
// R12 - invalid speed/mode error cases
// R13 - invalid command error cases
// R14 - latch open error on power/enable
// R15 - status bit 0 busy while executing
// R16 - slot interrupt locator bits
// R17 - completion interrupt locator bit 0
// R18 - slot system error locator bits
// R19 - arbiter system error locator bit 0
// R20 - wake term sets power event status
// R21 - interrupt when wake and unmasked
// R22 - system error when pending and unmasked
// R23 - arbiter timeout status, write one clears
// R24 - completion status and four masks reset one; the code resets completion status to zero
// R25 - slot enabled only when state 10b
// R26 - command code classification
package hpc_pkg;
  localparam logic [5:0] OFF_BASE     = 6'h00;
  localparam logic [5:0] OFF_AVAIL1   = 6'h04;
  localparam logic [5:0] OFF_AVAIL2   = 6'h08;
  localparam logic [5:0] OFF_SLOTCFG  = 6'h0c;
  localparam logic [5:0] OFF_BUSCFG   = 6'h10;
  localparam logic [5:0] OFF_CMD      = 6'h14;
  localparam logic [5:0] OFF_STATUS   = 6'h16;
  localparam logic [5:0] OFF_IRQLOC   = 6'h18;
  localparam logic [5:0] OFF_SERRLOC  = 6'h1c;
  localparam logic [5:0] OFF_SERRINT  = 6'h20;
  localparam logic [31:0] AVAIL1_MASK = 32'h1f1f1f1f;
  localparam logic [31:0] AVAIL2_MASK = 32'h0000001f;
  localparam logic [31:0] SLOTCFG_MASK = 32'he7ff1f1f;
  localparam logic [15:0] CMD_MASK    = 16'h1fff;
  localparam logic [3:0]  MASK_RESET  = 4'hf;
  localparam int COMPLETION_STATUS_BIT = 16;
  localparam int ATO_STS_BIT = 17;
  localparam int ERR_SPEED = 2;
  localparam int ERR_CMD = 1;
  localparam int ERR_LATCH = 0;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [1:0] SS_CODE_ENABLED = 2'h2;
  localparam logic [4:0] MODE_CMD_PREFIX = 5'h08;
  localparam logic [7:0] CMD_POWER_ALL = 8'h48;
  localparam logic [7:0] CMD_ENABLE_ALL = 8'h49;
  localparam logic [7:0] PROG_IF_DEFAULT = 8'h01; // arbitrary value

  typedef enum logic [1:0] {IND_KEEP, IND_ON, IND_BLINK, IND_OFF} hpc_ind_t;
  typedef enum logic [1:0] {SS_KEEP, SS_POWER, SS_ENABLE, SS_DISABLE} hpc_ss_t;
  typedef enum logic [1:0] {OP_SLOT, OP_MODE, OP_POWER_ALL, OP_ENABLE_ALL} hpc_kind_t;

  typedef struct packed {
    logic       start;
    hpc_kind_t  kind;
    logic [4:0] target;
    hpc_ind_t   attn;
    hpc_ind_t   power;
    hpc_ss_t    slot;
    logic [2:0] mode;
  } hpc_op_t;

  typedef struct packed {
    logic        busy;
    logic        failing;
    logic [2:0]  err;
    logic [2:0]  errPend;
    logic        ccSts;
    logic        atoSts;
    logic [3:0]  mask;
    logic [31:0] avail1;
    logic [31:0] avail2;
    logic [31:0] slotCfg;
    logic [2:0]  locked;
    logic [15:0] cmd;
    logic [23:0] arbCnt;
    hpc_op_t     op;
    logic [31:0] rdata;
    logic        wake;
    logic        irq;
    logic        serr;
  } hpc_state_t;

  function automatic logic [4:0] avail_at(input logic [2:0] mode,
                                          input logic [31:0] a1,
                                          input logic [31:0] a2);
    case (mode)
      3'h0: avail_at = a1[4:0];
      3'h1: avail_at = a2[4:0];
      3'h2: avail_at = a1[12:8];
      3'h3: avail_at = a1[20:16];
      3'h4: avail_at = a1[28:24];
      default: avail_at = 5'h00;
    endcase
  endfunction : avail_at
endpackage : hpc_pkg

/* File: verilog/hpc_cmd_check.sv */
// command classification and error checking for the hot plug controller
`timescale 1ns/1ps
module hpc_cmd_check (
  input  wire logic [7:0]       code,
  input  wire logic [4:0]       target_slot,
  input  wire logic [4:0]       slots_implemented,
  input  wire logic [2:0]       curMode,
  input  wire logic [31:0]      avail1,
  input  wire logic [31:0]      avail2,
  input  wire logic [3:0][1:0]  slotState,
  input  wire logic [3:0][2:0]  slotMaxMode,
  input  wire logic [3:0]       latchOpen,
  output hpc_pkg::hpc_kind_t    kind,
  output logic [2:0]            err
);
  logic       slotOp, modeOp, pwrAll, enAll, tgtOk, tgtEn;
  logic [1:0] idx;
  logic [2:0] reqMode, tgtMax;
  logic [4:0] availCur, availReq;
  logic [2:0] enCount;
  logic [3:0] enabled, implemented;
  logic       badCmd, badSpeed, badLatch, enSlowCur, enSlowReq, anySlow;

  always_comb begin
    slotOp = code[7:6] == 2'h0; // [R26]
    modeOp = code[7:3] == hpc_pkg::MODE_CMD_PREFIX;
    pwrAll = code == hpc_pkg::CMD_POWER_ALL;
    enAll  = code == hpc_pkg::CMD_ENABLE_ALL;
    reqMode = code[2:0];
    if (modeOp) kind = hpc_pkg::OP_MODE;
    else if (pwrAll) kind = hpc_pkg::OP_POWER_ALL;
    else if (enAll) kind = hpc_pkg::OP_ENABLE_ALL;
    else kind = hpc_pkg::OP_SLOT;
    tgtOk = target_slot != 5'h00 && target_slot <= slots_implemented && target_slot <= 5'h04;
    idx = 2'(target_slot - 5'h01);
    enCount = 3'h0;
    anySlow = 1'b0;
    enSlowCur = 1'b0;
    enSlowReq = 1'b0;
    for (int i = 0; i < 4; i++) begin
      enabled[i] = slotState[i] == hpc_pkg::SS_CODE_ENABLED; // [R25]
      implemented[i] = 5'(i + 1) <= slots_implemented;
      enCount = enCount + 3'(enabled[i]);
      if (implemented[i] && slotMaxMode[i] < curMode) anySlow = 1'b1;
      if (enabled[i] && slotMaxMode[i] < reqMode) enSlowReq = 1'b1;
    end
    tgtEn  = tgtOk && enabled[idx];
    tgtMax = slotMaxMode[idx];
    enSlowCur = tgtOk && tgtMax < curMode;
    availCur = hpc_pkg::avail_at(curMode, avail1, avail2);
    availReq = hpc_pkg::avail_at(reqMode, avail1, avail2);
    badCmd = !(slotOp || modeOp || pwrAll || enAll) // [R13]
          || (modeOp && reqMode > hpc_pkg::MODE_MAX)
          || (slotOp && !tgtOk)
          || (slotOp && code[1:0] == 2'(hpc_pkg::SS_ENABLE) && target_slot > availCur)
          || (slotOp && code[1:0] == 2'(hpc_pkg::SS_POWER) && tgtEn)
          || ((pwrAll || enAll) && enabled != 4'h0)
          || (modeOp && availReq == 5'h00);
    badSpeed = (slotOp && code[1:0] == 2'(hpc_pkg::SS_ENABLE) && enSlowCur) // [R12]
            || (enAll && anySlow)
            || (modeOp && enSlowReq)
            || (modeOp && availReq != 5'h00 && availReq < 5'(enCount));
    badLatch = slotOp && tgtOk && latchOpen[idx] // [R14]
            && (code[1:0] == 2'(hpc_pkg::SS_POWER) || code[1:0] == 2'(hpc_pkg::SS_ENABLE));
    err = 3'h0;
    if (badCmd) err[hpc_pkg::ERR_CMD] = 1'b1; // [R10]
    else if (badSpeed) err[hpc_pkg::ERR_SPEED] = 1'b1;
    else if (badLatch) err[hpc_pkg::ERR_LATCH] = 1'b1;
  end
endmodule : hpc_cmd_check

/* File: bench/hpc_slot_model.sv */
// slot sequencer stand-in: finishes each started operation after a random delay
`timescale 1ns/1ps
module hpc_slot_model (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire hpc_pkg::hpc_op_t op,
  output logic                  opDone
);
  int unsigned cnt;
  always @(posedge clk_sys) begin
    opDone <= !srst && !op.start && cnt == 1;
    if (srst)
      cnt <= 0;
    else if (op.start)
      cnt <= 1 + $urandom_range(11);
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule : hpc_slot_model

/* File: bench/hot_plug_controller_regs_tb_top.sv */
// self-checking bench for the hot plug controller register set
`timescale 1ns/1ps
module hot_plug_controller_regs_tb_top;
  typedef struct packed {
    logic [7:0] code;
    logic [4:0] target_slot;
    logic       lat;
    logic [2:0] bm;
    logic [1:0] ss;
    logic [2:0] mx;
    logic [2:0] ex;
  } hpc_row_t;
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  logic             hotplugEnable = 1'b1;
  logic [5:0]       regAddr = '0;
  logic             regWr = 1'b0;
  logic             regRd = 1'b0;
  logic [3:0]       regBe = '0;
  logic [31:0]      regWdata = '0;
  logic [31:0]      regRdata;
  logic [2:0]       busMode = '0;
  logic [3:0][1:0]  slotState = '1;
  logic [3:0][2:0]  slotMaxMode = {4{3'h4}};
  logic [3:0]       latchOpen = '0;
  logic [3:0][4:0]  slotIrqStatus = '0;
  logic [3:0][4:0]  slotIrqMask = '1;
  logic [3:0][1:0]  slotSerrStatus = '0;
  logic [3:0][1:0]  slotSerrMask = '1;
  logic             hpBusReq = 1'b0;
  logic             busGrant = 1'b0;
  logic             pclkTick = 1'b0;
  logic             opDone;
  logic             controllerBusy;
  logic             wakeTerm;
  logic             controllerIrq;
  logic             controllerSyserr;
  hpc_pkg::hpc_op_t op;
  int               error_cnt = 0;
  int               compares = 0;
  logic [31:0]      d;
  logic [31:0]      wo[3];
  logic [4:0]       irqE;
  logic [4:0]       serrE;
  logic [3:0]       m;
  logic             ccExp;
  logic             atoExp;
  hpc_row_t         r;
  hpc_row_t rows[17] = '{'{8'h02,1,0,0,3,4,0}, '{8'h02,1,1,0,3,4,1}, '{8'h01,0,0,0,3,4,2},
    '{8'h35,5,0,0,3,4,2}, '{8'h80,1,0,0,3,4,2}, '{8'h48,3,0,0,3,4,0}, '{8'h49,0,0,0,3,4,0},
    '{8'h44,2,0,0,3,4,0}, '{8'h45,0,0,0,3,4,2}, '{8'h02,1,0,1,3,0,4}, '{8'h01,1,0,0,2,4,2},
    '{8'h49,0,0,0,2,4,2}, '{8'h44,0,0,0,2,0,4}, '{8'h17,2,0,0,3,4,0}, '{8'h2b,3,0,0,3,4,0},
    '{8'h3e,4,0,0,3,4,0}, '{8'h05,1,0,0,3,4,0}};

  always #4 clk_sys = ~clk_sys;

  hpc_regs #(.ARB_TIMEOUT(16)) dut (.clk_sys(clk_sys), .srst(srst),
    .hotplugEnable(hotplugEnable), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regBe(regBe), .regWdata(regWdata), .regRdata(regRdata), .busMode(busMode),
    .slotState(slotState), .slotMaxMode(slotMaxMode), .latchOpen(latchOpen),
    .slotIrqStatus(slotIrqStatus), .slotIrqMask(slotIrqMask),
    .slotSerrStatus(slotSerrStatus), .slotSerrMask(slotSerrMask), .hpBusReq(hpBusReq),
    .busGrant(busGrant), .pclkTick(pclkTick), .opDone(opDone), .op(op),
    .controllerBusy(controllerBusy), .wakeTerm(wakeTerm), .controllerIrq(controllerIrq),
    .controllerSyserr(controllerSyserr));
  hpc_slot_model partner (.clk_sys(clk_sys), .srst(srst), .op(op), .opDone(opDone));

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr  <= a;
    regBe    <= b;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(n, e, regRdata);
  endtask : rchk

  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && controllerBusy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 40) begin
      chk("busy release", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : wait_idle

  // slot op, all-slot codes or a mode change; the kind decides which op fields matter
  function automatic logic [1:0] exp_kind(input logic [7:0] c);
    if (c[7:6] == 2'b00)
      return hpc_pkg::OP_SLOT;
    if (c == hpc_pkg::CMD_POWER_ALL)
      return hpc_pkg::OP_POWER_ALL;
    if (c == hpc_pkg::CMD_ENABLE_ALL)
      return hpc_pkg::OP_ENABLE_ALL;
    return hpc_pkg::OP_MODE;
  endfunction : exp_kind

  initial begin
    void'($urandom(32'h1fa4));
    repeat (20) @(posedge clk_sys);
    srst    <= 1'b0;
    busMode <= 3'($urandom_range(4));
    hotplugEnable <= 1'b0;
    wr(hpc_pkg::OFF_SERRINT, 4'hf, 32'h0);
    rchk("disabled read", hpc_pkg::OFF_SERRINT, 32'h0);
    @(posedge clk_sys) hotplugEnable <= 1'b1;
    rchk("mask reset", hpc_pkg::OFF_SERRINT, 32'hf);
    wr(hpc_pkg::OFF_BASE, 4'hf, 32'hffffffff);
    rchk("base word", hpc_pkg::OFF_BASE, 32'h0);
    rchk("bus config", hpc_pkg::OFF_BUSCFG, {hpc_pkg::PROG_IF_DEFAULT, 21'h0, busMode});
    rchk("irq locator", hpc_pkg::OFF_IRQLOC, 32'h0);
    rchk("unmapped", 6'h24, 32'h0);
    // counts of four keep every enable row legal on slot count alone
    wo = '{32'h04040404, 32'h4, ($urandom & hpc_pkg::SLOTCFG_MASK & ~32'h1f) | 32'h4};
    for (int k = 0; k < 3; k++) begin
      wr(6'(4 * k + 4), 4'hf, wo[k]);
      wr(6'(4 * k + 4), 4'hf, $urandom);
      rchk("write once", 6'(4 * k + 4), wo[k]);
    end
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk_sys);
      busMode        <= r.bm;
      slotState[0]   <= r.ss;
      slotMaxMode[0] <= r.mx;
      latchOpen[0]   <= r.lat;
      wr(hpc_pkg::OFF_CMD, 4'h3, {19'h0, r.target_slot, r.code});
      #1 chk("busy", 32'h1, 32'(controllerBusy));
      chk("start", 32'(r.ex == 3'h0), 32'(op.start));
      if (r.ex == 3'h0) begin
        chk("kind", 32'(exp_kind(r.code)), 32'(op.kind));
        chk("target", (r.code[7:6] == 2'b00) ? 32'(r.target_slot) : 32'h0, 32'(op.target));
        if (r.code[7:6] == 2'b00)
          chk("fields", 32'(r.code[5:0]), 32'({op.attn, op.power, op.slot}));
        if (exp_kind(r.code) == hpc_pkg::OP_MODE)
          chk("mode", 32'(r.code[2:0]), 32'(op.mode));
        wr(hpc_pkg::OFF_CMD, 4'h3, 32'h80);
      end
      wait_idle();
      rchk("status", hpc_pkg::OFF_STATUS, {28'h0, r.ex, 1'b0});
      rchk("command", hpc_pkg::OFF_CMD, {12'h0, r.ex, 4'h0, r.target_slot, r.code});
      rchk("completion", hpc_pkg::OFF_SERRINT, 32'h1000f);
    end
    @(posedge clk_sys);
    hpBusReq <= 1'b1;
    pclkTick <= 1'b1;
    // read lands on the last tick before the limit
    repeat (14) @(posedge clk_sys);
    rchk("early timeout", hpc_pkg::OFF_SERRINT, 32'h1000f);
    repeat (10) @(posedge clk_sys);
    hpBusReq <= 1'b0;
    rchk("timeout", hpc_pkg::OFF_SERRINT, 32'h3000f);
    ccExp  = 1'b1;
    atoExp = 1'b1;
    for (int k = 0; k < 14; k++) begin
      @(posedge clk_sys);
      slotIrqStatus  <= 20'($urandom);
      slotIrqMask    <= 20'($urandom);
      slotSerrStatus <= 8'($urandom);
      slotSerrMask   <= 8'($urandom);
      m = 4'($urandom);
      wr(hpc_pkg::OFF_SERRINT, (k == 7) ? 4'h5 : 4'h1, {14'h0, 2'b11, 12'h0, m});
      if (k == 7) begin
        ccExp  = 1'b0;
        atoExp = 1'b0;
      end
      for (int n = 0; n < 4; n++) begin
        irqE[n + 1]  = |(slotIrqStatus[n] & ~slotIrqMask[n]);
        serrE[n + 1] = |(slotSerrStatus[n] & ~slotSerrMask[n]);
      end
      irqE[0]  = ccExp & ~m[2];
      serrE[0] = atoExp & ~m[3];
      rchk("irq locator", hpc_pkg::OFF_IRQLOC, {27'h0, irqE});
      rchk("system_error_locator", hpc_pkg::OFF_SERRLOC, {27'h0, serrE});
      rchk("mask word", hpc_pkg::OFF_SERRINT, {14'h0, atoExp, ccExp, 12'h0, m});
      chk("wake", 32'(|irqE), 32'(wakeTerm));
      chk("irq", 32'(|irqE & ~m[0]), 32'(controllerIrq));
      chk("syserr", 32'(|serrE & ~m[1]), 32'(controllerSyserr));
    end
    give_verdict();
  end
endmodule : hot_plug_controller_regs_tb_top
